// ===== logic/piv_ctrl.v
`timescale 1ns/1ps
`include "piv_map.vh"
module piv_ctrl (
    input wire clk,
    input wire rst,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire ext_req_level_seven,
    input wire ext_req_level_six,
    input wire ext_req_level_three,
    input wire ext_req_level_two,
    input wire ext_req_level_one,
    input wire touch_pen_request,
    input wire spi_slave_req,
    input wire spi_master_req,
    input wire timer1_req,
    input wire timer2_req,
    input wire uart_req,
    input wire wdog_req,
    input wire rtc_req,
    input wire kbd_req,
    input wire pwm_req,
    input wire [7:0] gp_req,
    output reg [2:0] cpu_int_level_q,
    input wire iack_req,
    input wire [2:0] iack_level,
    output reg [7:0] iack_vector_q,
    output reg iack_done_q
);

// ------------------------------------------------------------
// registers
// ------------------------------------------------------------
reg [4:0] vector_base_field_q;
reg vec_set_q;
reg [7:0] ctl_q;
reg [23:0] mask_q;
reg aw_got_q;
reg w_got_q;
reg [3:0] awaddr_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg [23:0] prev_q;
reg [23:0] latch_q;

wire [23:0] raw_in;
wire [23:0] edge_sel;
wire [23:0] pol_sel;
wire [23:0] asserted;
wire [23:0] pending_status_register;
wire [23:0] active;
wire [7:1] lvl_req;
wire [2:0] lvl_top;
wire do_write;
wire [23:0] clr_bits;

// ------------------------------------------------------------
// source collection
// ------------------------------------------------------------
// bit order matches the mask register layout; bit 5 is unused
assign raw_in = {ext_req_level_seven, timer1_req, spi_slave_req,
                 touch_pen_request, ext_req_level_six, ext_req_level_three,
                 ext_req_level_two, ext_req_level_one, gp_req,
                 pwm_req, kbd_req, 1'b0, rtc_req, wdog_req, uart_req,
                 timer2_req, spi_master_req};

// only the four configurable pins take polarity and edge select;
// pin seven is a fixed active-low level, internal sources active high
// control bits run pin one, two, three, six from the top down,
// while source bits 16..19 run the other way round
assign edge_sel = {4'h0, ctl_q[0], ctl_q[1], ctl_q[2], ctl_q[3], 16'h0000};
assign pol_sel = {1'b0, 3'b111, ctl_q[4], ctl_q[5], ctl_q[6], ctl_q[7], 16'hffff};

// ------------------------------------------------------------
// per-source conditioning
// ------------------------------------------------------------
genvar gi;
generate
    for (gi = 0; gi < `PIV_NSRC; gi = gi + 1) begin : g_src
        assign asserted[gi] = pol_sel[gi] ? raw_in[gi] : ~raw_in[gi];
        always @(posedge clk or posedge rst) begin
            if (rst) begin
                prev_q[gi] <= 1'b0;
                latch_q[gi] <= 1'b0;
            end else begin
                prev_q[gi] <= asserted[gi];
                // a new edge wins over a clear in the same cycle
                if (edge_sel[gi] && asserted[gi] && !prev_q[gi]) begin
                    latch_q[gi] <= 1'b1;
                end else if (clr_bits[gi]) begin
                    latch_q[gi] <= 1'b0;
                end
            end
        end
        assign pending_status_register[gi] = edge_sel[gi] ? latch_q[gi] :
                                             asserted[gi];
    end
endgenerate

// masked sources stay visible in pending, but never reach the core
assign active = pending_status_register & ~mask_q & `PIV_USED_SET;

// ------------------------------------------------------------
// level grouping and priority
// ------------------------------------------------------------
assign lvl_req[7] = |(active & `PIV_LVL7_SET);
assign lvl_req[6] = |(active & `PIV_LVL6_SET);
assign lvl_req[5] = |(active & `PIV_LVL5_SET);
assign lvl_req[4] = |(active & `PIV_LVL4_SET);
assign lvl_req[3] = |(active & `PIV_LVL3_SET);
assign lvl_req[2] = |(active & `PIV_LVL2_SET);
assign lvl_req[1] = |(active & `PIV_LVL1_SET);

piv_level_enc u_enc (
    .lvl_req(lvl_req),
    .lvl_top(lvl_top)
);

// rst is an input only; nothing here can drive a reset outward
always @(posedge clk or posedge rst) begin
    if (rst) begin
        cpu_int_level_q <= 3'h0;
    end else begin
        cpu_int_level_q <= lvl_top;
    end
end

// ------------------------------------------------------------
// interrupt acknowledge
// ------------------------------------------------------------
// answered one clock after the request, no wait states; there is no
// autovector path, so an explicit vector is always returned
always @(posedge clk or posedge rst) begin
    if (rst) begin
        iack_vector_q <= 8'h00;
        iack_done_q <= 1'b0;
    end else begin
        iack_done_q <= iack_req && !iack_done_q;
        if (iack_req && !iack_done_q) begin
            if (!vec_set_q) begin
                iack_vector_q <= `PIV_UNINIT_VEC;
            end else begin
                iack_vector_q <= {vector_base_field_q, iack_level};
            end
        end
    end
end

// ------------------------------------------------------------
// axi4-lite write channel
// ------------------------------------------------------------
assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
assign s_axi_wready = !w_got_q && !s_axi_bvalid;
assign do_write = aw_got_q && w_got_q && !s_axi_bvalid;
assign clr_bits = (do_write && awaddr_q == `PIV_ADDR_PEND) ?
                  wdata_q[23:0] & edge_sel : 24'h000000;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        awaddr_q <= 4'h0;
        wdata_q <= 32'h00000000;
        wstrb_q <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `PIV_RESP_OKAY;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[3:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
        if (do_write) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `PIV_RESP_OKAY;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ------------------------------------------------------------
// register updates
// ------------------------------------------------------------
always @(posedge clk or posedge rst) begin
    if (rst) begin
        vector_base_field_q <= `PIV_VEC_RST;
        vec_set_q <= 1'b0;
        ctl_q <= `PIV_CTL_RST;
        mask_q <= `PIV_MASK_RST;
    end else if (do_write) begin
        case (awaddr_q)
            `PIV_ADDR_VEC: begin
                if (wstrb_q[0]) begin
                    vector_base_field_q <= wdata_q[7:3];
                    vec_set_q <= 1'b1;
                end
            end
            `PIV_ADDR_CTL: begin
                if (wstrb_q[1]) begin
                    ctl_q <= wdata_q[15:8];
                end
            end
            `PIV_ADDR_MASK: begin
                if (wstrb_q[0]) begin
                    mask_q[7:0] <= wdata_q[7:0];
                end
                if (wstrb_q[1]) begin
                    mask_q[15:8] <= wdata_q[15:8];
                end
                if (wstrb_q[2]) begin
                    mask_q[23:16] <= wdata_q[23:16];
                end
            end
            default: begin
                vec_set_q <= vec_set_q;
            end
        endcase
    end
end

// ------------------------------------------------------------
// axi4-lite read channel
// ------------------------------------------------------------
assign s_axi_arready = !s_axi_rvalid;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `PIV_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `PIV_RESP_OKAY;
        case ({s_axi_araddr[3:2], 2'b00})
            `PIV_ADDR_VEC: begin
                s_axi_rdata <= {24'h000000, vector_base_field_q, 3'b000};
            end
            `PIV_ADDR_CTL: begin
                s_axi_rdata <= {16'h0000, ctl_q, 8'h00};
            end
            `PIV_ADDR_MASK: begin
                s_axi_rdata <= {8'h00, mask_q};
            end
            `PIV_ADDR_PEND: begin
                s_axi_rdata <= {8'h00, pending_status_register};
            end
            default: begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `PIV_RESP_SLVERR;
            end
        endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

endmodule

// ===== logic/piv_map.vh
// Notes on behaviour
// - 23 sources, edge or level, seven levels
// - level 7 most urgent, level 1 least
// - pin seven at 7; slave, timer one, pin six at 6
// - master, timer two, peripherals, eight inputs at 4
// - pins three, two, one at 3, 2, 1
// - post only highest pending unmasked level
// - answer acknowledge with vector for given level
// - vector is five base bits plus level code
// - never autovector; always return explicit vector
// - mask blocks request; pending still readable
// - reset instruction never drives reset pin
// - unprogrammed base returns vector 0x0f
// - low three base bits read zero, ignore writes
// - all masks set after reset
`ifndef PIV_MAP_VH
`define PIV_MAP_VH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define PIV_ADDR_VEC 4'h0
`define PIV_ADDR_CTL 4'h4
`define PIV_ADDR_MASK 4'h8
`define PIV_ADDR_PEND 4'hc

// ------------------------------------------------------------
// reset values and fields
// ------------------------------------------------------------
`define PIV_VEC_RST 5'h00
`define PIV_CTL_RST 8'h00
`define PIV_MASK_RST 24'hffffff
`define PIV_UNINIT_VEC 8'h0f
`define PIV_NSRC 24
`define PIV_CTL_POL_LSB 12
`define PIV_CTL_ET_LSB 8
`define PIV_RESP_OKAY 2'b00
`define PIV_RESP_SLVERR 2'b10

// ------------------------------------------------------------
// source bit positions
// ------------------------------------------------------------
`define PIV_SRC_SPIM 0
`define PIV_SRC_TMR2 1
`define PIV_SRC_UART 2
`define PIV_SRC_WDT 3
`define PIV_SRC_RTC 4
`define PIV_SRC_KB 6
`define PIV_SRC_PWM 7
`define PIV_SRC_GP0 8
`define PIV_SRC_EXT1 16
`define PIV_SRC_EXT2 17
`define PIV_SRC_EXT3 18
`define PIV_SRC_EXT6 19
`define PIV_SRC_PEN 20
`define PIV_SRC_SPIS 21
`define PIV_SRC_TMR1 22
`define PIV_SRC_EXT7 23

// ------------------------------------------------------------
// sources per level (bit 5 is unused)
// ------------------------------------------------------------
`define PIV_LVL7_SET 24'h800000
`define PIV_LVL6_SET 24'h680000
`define PIV_LVL5_SET 24'h100000
`define PIV_LVL4_SET 24'h00ffdf
`define PIV_LVL3_SET 24'h040000
`define PIV_LVL2_SET 24'h020000
`define PIV_LVL1_SET 24'h010000
`define PIV_USED_SET 24'hffffdf

`endif

// ===== logic/piv_level_enc.v
`timescale 1ns/1ps
module piv_level_enc (
    input wire [7:1] lvl_req,
    output reg [2:0] lvl_top
);

// ------------------------------------------------------------
// highest requested level wins
// ------------------------------------------------------------
integer k;
always @* begin
    lvl_top = 3'h0;
    for (k = 1; k <= 7; k = k + 1) begin
        if (lvl_req[k]) begin
            lvl_top = k[2:0];
        end
    end
end

endmodule

// ===== sim/piv_ctrl_sva.sv
`timescale 1ns/1ps
module piv_ctrl_sva (
    input logic clk,
    input logic rst,
    input logic [3:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic ext_req_level_seven,
    input logic touch_pen_request,
    input logic [2:0] cpu_int_level_q,
    input logic iack_req,
    input logic [2:0] iack_level,
    input logic [7:0] iack_vector_q,
    input logic iack_done_q
);
    // ------------------------------------------------------------
    // mask address seen since reset
    // ------------------------------------------------------------
    // set at the address beat, ahead of the write itself, so it never lags
    logic mwr_q;
    always @(posedge clk or posedge rst) begin
        if (rst)
            mwr_q <= 1'b0;
        else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr[3:2] == 2'h2)
            mwr_q <= 1'b1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_ack_fast: assert property (iack_req && !iack_done_q |=> iack_done_q)
        else $error("acknowledge late");
    a_ack_once: assert property (iack_done_q |=> !iack_done_q)
        else $error("acknowledge too long");
    a_ack_cause: assert property (iack_done_q |-> $past(iack_req))
        else $error("acknowledge unasked");
    a_vec_code: assert property (iack_done_q |-> (iack_vector_q == 8'h0f ||
        iack_vector_q[2:0] == $past(iack_level))) else $error("vector level code");
    a_masked_rst: assert property (!mwr_q |-> cpu_int_level_q == 3'h0)
        else $error("request while masked");
    a_top_seven: assert property (cpu_int_level_q == 3'h7 |-> !$past(ext_req_level_seven))
        else $error("level seven without pin");
    a_pen_five: assert property (cpu_int_level_q == 3'h5 |-> $past(touch_pen_request))
        else $error("level five without pen");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    cover property (iack_done_q && iack_vector_q == 8'h0f);
    cover property (cpu_int_level_q == 3'h7);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind piv_ctrl piv_ctrl_sva u_sva (.*);

// ===== sim/piv_cpu_model.sv
`timescale 1ns/1ps
module piv_cpu_model (
    input logic clk,
    input logic rst,
    input logic go,
    input logic [2:0] go_lvl,
    input logic rte,
    input logic iack_done_q,
    input logic [7:0] iack_vector_q,
    output logic iack_req,
    output logic [2:0] iack_level,
    output logic [7:0] vec_seen,
    output logic [9:0] vec_addr
);
    logic [2:0] ipm_q;
    // rte stands for a handler return and reopens the mask fully
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            iack_req <= 1'b0;
            iack_level <= 3'h0;
            ipm_q <= 3'h7;
            vec_seen <= 8'h00;
        end else if (iack_req && iack_done_q) begin
            iack_req <= 1'b0;
            vec_seen <= iack_vector_q;
            ipm_q <= iack_level;
        end else if (rte) begin
            ipm_q <= 3'h0;
        end else if (go && !iack_req && go_lvl > ipm_q) begin
            iack_req <= 1'b1;
            iack_level <= go_lvl;
        end
    end
    assign vec_addr = {vec_seen, 2'b00};
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`include "piv_map.vh"
module tb_top;
    logic clk, rst, go, rte;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, rd_q;
    logic [23:0] src, m;
    logic [2:0] go_lvl;
    logic [1:0] br_q, rr_q;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire iack_req, iack_done_q;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [2:0] cpu_int_level_q, iack_level;
    wire [7:0] iack_vector_q, vec_seen;
    wire [9:0] vec_addr;
    int err_count, n_tests, cyc, b, l;
    // src holds asserted sources in register bit order; pins are active low
    piv_ctrl DUT (.*, .ext_req_level_seven(~src[23]), .ext_req_level_six(~src[19]),
        .ext_req_level_three(~src[18]), .ext_req_level_two(~src[17]),
        .ext_req_level_one(~src[16]), .touch_pen_request(src[20]), .spi_slave_req(src[21]),
        .spi_master_req(src[0]), .timer1_req(src[22]), .timer2_req(src[1]),
        .uart_req(src[2]), .wdog_req(src[3]), .rtc_req(src[4]), .kbd_req(src[6]),
        .pwm_req(src[7]), .gp_req(src[15:8]));
    piv_cpu_model u_cpu (.*);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task test_done;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            test_done;
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task chl(input int e);
        chk({29'h0, cpu_int_level_q}, e);
    endtask
    function automatic int lvl_of(input int k);
        if (k == 23) return 7;
        if (k == 19 || k == 21 || k == 22) return 6;
        if (k == 20) return 5;
        if (k > 15) return k - 15;
        return (k == 5) ? 0 : 4;
    endfunction
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task put_src(input logic [23:0] v);
        @(posedge clk);
        src <= v;
        settle;
    endtask
    // readiness is sampled mid-cycle so the release edge is never raced
    task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        logic ta, tw, tk;
        int i;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        tk = 1'b0;
        for (i = 0; i < 20 && !tk; i++) begin
            @(negedge clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tk = s_axi_bvalid;
            br_q = s_axi_bresp;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        if (!tk) err_count++;
    endtask
    task rd(input logic [3:0] a);
        logic ta, tk;
        int i;
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        tk = 1'b0;
        for (i = 0; i < 20 && !tk; i++) begin
            @(negedge clk);
            ta = s_axi_arvalid && s_axi_arready;
            tk = s_axi_rvalid;
            rd_q = s_axi_rdata;
            rr_q = s_axi_rresp;
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        if (!tk) err_count++;
    endtask
    task ack(input logic [2:0] lv, input logic [7:0] ev);
        int i;
        @(posedge clk);
        rte <= 1'b1;
        @(posedge clk);
        {rte, go, go_lvl} <= {2'b01, lv};
        @(posedge clk);
        go <= 1'b0;
        #1;
        for (i = 0; i < 20 && iack_req; i++) @(posedge clk) #1;
        chk(vec_seen, ev);
        chk(vec_addr, {ev, 2'b00});
        // no bus error is ever signalled, so the spurious vector must not appear
        chk(32'(vec_seen == 8'h18), 32'(ev == 8'h18));
    endtask
    initial begin
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {go, rte, go_lvl, s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata, src} = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(`PIV_ADDR_MASK);
        chk(rd_q, 32'h00ffffff);
        chk({30'h0, rr_q}, {30'h0, `PIV_RESP_OKAY});
        rd(`PIV_ADDR_VEC);
        chk(rd_q, 32'h0);
        put_src(24'h100000);
        chl(0);
        wr(`PIV_ADDR_MASK, 32'h00efffff, 4'hf);
        settle;
        chl(5);
        ack(3'h5, 8'h0f);
        wr(`PIV_ADDR_VEC, 32'h47, 4'h1);
        chk({30'h0, br_q}, {30'h0, `PIV_RESP_OKAY});
        rd(`PIV_ADDR_VEC);
        chk(rd_q, 32'h40);
        ack(3'h5, 8'h45);
        wr(`PIV_ADDR_MASK, 32'h0, 4'hf);
        for (b = 0; b < 24; b++) begin
            put_src(24'h1 << b);
            chl(lvl_of(b));
            if (b != 5) ack(3'(lvl_of(b)), 8'h40 | 8'(lvl_of(b)));
            rd(`PIV_ADDR_PEND);
            chk({31'h0, rd_q[b]}, 32'(b != 5));
        end
        put_src(24'hffffff);
        m = 24'h0;
        for (l = 7; l > 0; l--) begin
            wr(`PIV_ADDR_MASK, {8'h0, m}, 4'hf);
            settle;
            chl(l);
            for (b = 0; b < 24; b++) if (lvl_of(b) == l) m[b] = 1'b1;
        end
        wr(`PIV_ADDR_MASK, {8'h0, m}, 4'hf);
        settle;
        chl(0);
        rd(`PIV_ADDR_PEND);
        chk(rd_q, 32'h00ffffdf);
        put_src(24'h0);
        wr(`PIV_ADDR_MASK, 32'h00feffff, 4'hf);
        wr(`PIV_ADDR_CTL, 32'h0800, 4'h2);
        wr(`PIV_ADDR_PEND, 32'h10000, 4'hf);
        put_src(24'h010000);
        put_src(24'h0);
        chl(1);
        wr(`PIV_ADDR_PEND, 32'h10000, 4'hf);
        settle;
        chl(0);
        test_done;
    end
endmodule
